// ===== design/lcds_pkg.sv
// constants, field layouts and carrier types of the lcd setting decoder
// assumes one 25 MHz clock and a wishbone master on the same clock
package lcds_pkg;
	// register byte addresses (word aligned)
	localparam logic [3:0] LCDS_ADR_BYTE = 4'h0; // write: {dc, byte}
	localparam logic [3:0] LCDS_ADR_STAT = 4'h4; // read: settings
	localparam logic [3:0] LCDS_ADR_PTR = 4'h8; // read: pointers
	localparam logic [3:0] LCDS_ADR_RAM = 4'hc; // read: ram at pointers
	// byte register field positions
	localparam int LCDS_DC_BIT = 8;
	// geometry
	localparam logic [6:0] LCDS_COL_MAX = 7'h65;
	localparam logic [3:0] LCDS_BANK_MAX = 4'h8;
	localparam int LCDS_RAM_WORDS = 1020; // ten banks of 102 columns; only banks 0 to 8 are used
	localparam int LCDS_ROWS = 65;
	// row block boundaries
	localparam int LCDS_LO_A0 = 0;
	localparam int LCDS_LO_A1 = 18;
	localparam int LCDS_UP_A0 = 19;
	localparam int LCDS_UP_A1 = 32;
	localparam int LCDS_LO_B0 = 33;
	localparam int LCDS_LO_B1 = 50;
	localparam int LCDS_UP_B0 = 51;
	localparam int LCDS_UP_B1 = 64;
	// display mode codes {hi, lo}
	localparam logic [1:0] LCDS_MODE_BLANK = 2'h0;
	localparam logic [1:0] LCDS_MODE_NORMAL = 2'h2;
	localparam logic [1:0] LCDS_MODE_ALLON = 2'h1;
	localparam logic [1:0] LCDS_MODE_INV = 2'h3;
	// settings carrier
	typedef struct packed {
		logic power_down_flag;
		logic addressing_direction_sel;
		logic extended_set_sel;
		logic column_mirror;
		logic row_flip;
		logic upper_row_block_flip;
		logic lower_row_block_flip;
		logic display_mode_hi;
		logic display_mode_lo;
		logic high_range_sel;
		logic [1:0] multiplier_stage_sel;
		logic [1:0] temp_coeff_sel;
		logic [2:0] bias_factor_sel;
		logic [6:0] drive_level_code;
	} lcds_set_type;
	localparam lcds_set_type LCDS_SET_RESET = '{power_down_flag: 1'b1, default: '0};
	// whole state of the decoder
	typedef struct packed {
		lcds_set_type set;
		logic [6:0] column_pointer;
		logic [3:0] bank_pointer;
		logic ack;
		logic ram_rd_sel; // answer of this cycle comes from the ram
		logic [31:0] dat;
	} lcds_state_type;
endpackage

// ===== design/lcds_decoder.sv
// lcd setting decoder: wishbone slave taking command and data bytes
// assumes a classic wishbone master on clk_i; reset pad already synchronised
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module lcds_decoder
	import lcds_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [7:0] ram_wdata_o,
	output logic ram_we_o,
	output logic [6:0] ram_col_o,
	output logic [3:0] ram_bank_o,
	output logic lcd_outputs_off_o,
	output logic bias_gen_en_o,
	output logic osc_en_o,
	output logic charge_pump_en_o,
	output logic [1:0] display_mode_o,
	output logic [LCDS_ROWS-1:0] row_map_sel_o,
	output lcds_set_type settings_o
);
	lcds_state_type st_reg;
	lcds_state_type st_next;
	// display ram; reset never touches it
	logic [7:0] ram_mem [0:LCDS_RAM_WORDS-1];
	logic [7:0] ram_rd;
	logic [9:0] ram_idx;
	logic [7:0] cmd;
	logic is_data;
	logic wr_byte;
	logic take;
	logic cmd_write;
	logic data_write;
	logic bus_read;
	logic page_basic;
	logic page_ext;
	logic dec_func_set;
	logic dec_range;
	logic dec_disp_ctl;
	logic dec_stages;
	logic dec_bank;
	logic dec_col;
	logic dec_temp;
	logic dec_disp_cfg;
	logic dec_bias;
	logic dec_vop;
	logic col_ok;
	logic bank_ok;
	logic col_last;
	logic bank_last;
	logic [6:0] col_inc;
	logic [3:0] bank_inc;
	logic [6:0] col_adv;
	logic [3:0] bank_adv;
	// columns per bank, one past the last column
	localparam logic [9:0] BANK_STRIDE = 10'(LCDS_COL_MAX) + 10'h001;

	// one-cycle answer to each request; nothing is taken while reset is applied
	assign take = wb_cyc_i && wb_stb_i && !st_reg.ack && !rst_i;
	assign wr_byte = take && wb_we_i && wb_sel_i[0] && wb_adr_i == LCDS_ADR_BYTE;
	assign bus_read = take && !wb_we_i;
	assign cmd = wb_dat_i[7:0];
	assign is_data = wb_dat_i[LCDS_DC_BIT];
	assign data_write = wr_byte && is_data;
	assign cmd_write = wr_byte && !is_data;

	// page split; function set and data writes ignore it
	assign page_basic = !st_reg.set.extended_set_sel;
	assign page_ext = st_reg.set.extended_set_sel;
	// function set is the only command of both pages
	assign dec_func_set = cmd[7:5] == 3'b001;
	// basic page commands; reserved codes match none of them
	assign dec_range = page_basic && cmd[7:1] == 7'b0000010;
	assign dec_disp_ctl = page_basic && cmd[7:3] == 5'b00001 && !cmd[1];
	assign dec_stages = page_basic && cmd[7:2] == 6'b000100;
	assign dec_bank = page_basic && cmd[7:4] == 4'b0100;
	assign dec_col = page_basic && cmd[7];
	// extended page commands; the reserved test range is left alone
	assign dec_temp = page_ext && cmd[7:2] == 6'b000001;
	assign dec_disp_cfg = page_ext && cmd[7:3] == 5'b00001;
	assign dec_bias = page_ext && cmd[7:3] == 5'b00010;
	assign dec_vop = page_ext && cmd[7];

	// pointer loads beyond the ram are ignored, the pointer keeps its value
	assign col_ok = cmd[6:0] <= LCDS_COL_MAX;
	assign bank_ok = cmd[3:0] <= LCDS_BANK_MAX;

	// pointer advance: horizontal steps columns first, vertical steps banks first
	assign col_last = st_reg.column_pointer >= LCDS_COL_MAX;
	assign bank_last = st_reg.bank_pointer >= LCDS_BANK_MAX;
	assign col_inc = col_last ? 7'h00 : 7'(st_reg.column_pointer + 7'h01);
	assign bank_inc = bank_last ? 4'h0 : 4'(st_reg.bank_pointer + 4'h1);
	assign col_adv = (!st_reg.set.addressing_direction_sel || bank_last) ? col_inc
		: st_reg.column_pointer;
	assign bank_adv = (st_reg.set.addressing_direction_sel || col_last) ? bank_inc
		: st_reg.bank_pointer;

	// mirrored column placement for writes
	assign ram_col_o = st_reg.set.column_mirror ? 7'(LCDS_COL_MAX - st_reg.column_pointer)
		: st_reg.column_pointer;
	assign ram_bank_o = st_reg.bank_pointer;
	// widened before the product so bank 8 does not wrap the index
	assign ram_idx = 10'(st_reg.bank_pointer) * BANK_STRIDE + 10'(ram_col_o);
	assign ram_we_o = data_write;
	// bank 8 stores only the msb
	assign ram_wdata_o = (st_reg.bank_pointer == LCDS_BANK_MAX) ? {cmd[7], 7'h00} : cmd;

	// ram write port, also in power-down
	always_ff @(posedge clk_i) begin
		if (ram_we_o) begin
			ram_mem[ram_idx] <= ram_wdata_o;
		end
		ram_rd <= ram_mem[ram_idx];
	end

	// command decode, pointer advance and bus answer
	always_comb begin
		st_next = st_reg;
		st_next.ack = take;
		st_next.ram_rd_sel = bus_read && wb_adr_i == LCDS_ADR_RAM;
		// a data byte moves the pointers on, also in power-down
		if (data_write) begin
			st_next.column_pointer = col_adv;
			st_next.bank_pointer = bank_adv;
		end
		// each command stands alone, so any order is accepted
		if (cmd_write && dec_func_set) begin
			st_next.set.column_mirror = cmd[4];
			st_next.set.row_flip = cmd[3];
			st_next.set.power_down_flag = cmd[2];
			st_next.set.addressing_direction_sel = cmd[1];
			st_next.set.extended_set_sel = cmd[0];
		end
		// basic page: pointers, stages, display mode, range
		if (cmd_write && dec_col && col_ok) begin
			st_next.column_pointer = cmd[6:0];
		end
		if (cmd_write && dec_bank && bank_ok) begin
			st_next.bank_pointer = cmd[3:0];
		end
		if (cmd_write && dec_stages) begin
			st_next.set.multiplier_stage_sel = cmd[1:0];
		end
		if (cmd_write && dec_disp_ctl) begin
			st_next.set.display_mode_hi = cmd[2];
			st_next.set.display_mode_lo = cmd[0];
		end
		if (cmd_write && dec_range) begin
			st_next.set.high_range_sel = cmd[0];
		end
		// extended page: drive level, bias, row blocks, temperature
		if (cmd_write && dec_vop) begin
			st_next.set.drive_level_code = cmd[6:0];
		end
		if (cmd_write && dec_bias) begin
			st_next.set.bias_factor_sel = cmd[2:0];
		end
		if (cmd_write && dec_disp_cfg) begin
			st_next.set.upper_row_block_flip = cmd[1];
			st_next.set.lower_row_block_flip = cmd[0];
		end
		if (cmd_write && dec_temp) begin
			st_next.set.temp_coeff_sel = cmd[1:0];
		end
		// read data, unmapped reads give zero
		st_next.dat = 32'h0000_0000;
		if (bus_read) begin
			unique case (wb_adr_i)
				LCDS_ADR_STAT: st_next.dat = 32'(st_reg.set);
				LCDS_ADR_PTR: st_next.dat = 32'({st_reg.bank_pointer, st_reg.column_pointer});
				default: st_next.dat = 32'h0000_0000;
			endcase
		end
		// reset restores settings and pointers, never the ram
		if (rst_i) begin
			st_next = '0;
			st_next.set = LCDS_SET_RESET;
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		st_reg <= st_next;
	end

	// ram reads answer from the synchronous ram output, in step with ack
	assign wb_dat_o = st_reg.ram_rd_sel ? {24'h00_0000, ram_rd} : st_reg.dat;
	assign wb_ack_o = st_reg.ack;

	// power-down and charge-pump control
	assign lcd_outputs_off_o = st_reg.set.power_down_flag;
	assign bias_gen_en_o = !st_reg.set.power_down_flag;
	assign osc_en_o = !st_reg.set.power_down_flag;
	assign charge_pump_en_o = !st_reg.set.power_down_flag
		&& (st_reg.set.high_range_sel || st_reg.set.drive_level_code != 7'h00);
	assign display_mode_o = st_reg.set.power_down_flag ? LCDS_MODE_BLANK
		: {st_reg.set.display_mode_hi, st_reg.set.display_mode_lo};
	assign settings_o = st_reg.set;

	// physical row to logical row map: flips within blocks, then row flip
	genvar r;
	generate
		for (r = 0; r < LCDS_ROWS; r++) begin : g_row
			localparam int LO = (r <= LCDS_LO_A1) ? LCDS_LO_A0 : (r <= LCDS_UP_A1) ? LCDS_UP_A0
				: (r <= LCDS_LO_B1) ? LCDS_LO_B0 : LCDS_UP_B0;
			localparam bit UPPER = (LO == LCDS_UP_A0) || (LO == LCDS_UP_B0);
			logic blk;
			assign blk = UPPER ? st_reg.set.upper_row_block_flip
				: st_reg.set.lower_row_block_flip;
			// marks a row whose source is swapped; row flip applies immediately
			assign row_map_sel_o[r] = blk ^ st_reg.set.row_flip;
		end
	endgenerate
endmodule // lcds_decoder
`default_nettype wire

// ===== dv/lcds_decoder_props.sv
// checker for the lcd setting decoder, bound onto lcds_decoder
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module lcds_decoder_props
	import lcds_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic ram_we_o,
	input wire logic [6:0] ram_col_o,
	input wire logic [3:0] ram_bank_o,
	input wire logic lcd_outputs_off_o,
	input wire logic bias_gen_en_o,
	input wire logic osc_en_o,
	input wire logic charge_pump_en_o,
	input wire logic [1:0] display_mode_o,
	input wire logic [LCDS_ROWS-1:0] row_map_sel_o,
	input wire lcds_set_type settings_o
);
	logic [LCDS_ROWS-1:0] map_exp;
	// expected row swap per row: block flip of its group xor row flip
	always_comb begin
		for (int r = 0; r < LCDS_ROWS; r++) begin
			map_exp[r] = settings_o.row_flip ^ (((r >= LCDS_UP_A0 && r <= LCDS_UP_A1)
				|| r >= LCDS_UP_B0) ? settings_o.upper_row_block_flip
				: settings_o.lower_row_block_flip);
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// bus answer and settings relations
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one cycle after request");
	chk_reset_vals: assert property ($past(rst_i) |-> settings_o == LCDS_SET_RESET)
		else $error("settings wrong after reset");
	chk_pd_outputs: assert property (settings_o.power_down_flag |-> lcd_outputs_off_o && !bias_gen_en_o
		&& !osc_en_o && !charge_pump_en_o && display_mode_o == LCDS_MODE_BLANK)
		else $error("power-down outputs wrong");
	chk_pump_off: assert property (settings_o.drive_level_code == 7'h00 && !settings_o.high_range_sel
		|-> !charge_pump_en_o)
		else $error("charge pump on with zero drive");
	chk_mode_out: assert property (!settings_o.power_down_flag |-> display_mode_o
		== {settings_o.display_mode_hi, settings_o.display_mode_lo})
		else $error("display mode output wrong");
	chk_row_map: assert property (row_map_sel_o == map_exp)
		else $error("row map wrong");
	chk_ram_source: assert property (ram_we_o |-> wb_cyc_i && wb_stb_i && wb_we_i
		&& wb_adr_i == LCDS_ADR_BYTE && wb_dat_i[LCDS_DC_BIT])
		else $error("ram write without data byte");
	chk_ram_range: assert property (ram_we_o |-> ram_bank_o <= LCDS_BANK_MAX
		&& ram_col_o <= LCDS_COL_MAX)
		else $error("ram write out of range");
	cov_ram_pd: cover property (ram_we_o && settings_o.power_down_flag);
	cov_vert: cover property (ram_we_o && settings_o.addressing_direction_sel);
	cov_flip: cover property (settings_o.row_flip && settings_o.upper_row_block_flip);
endmodule // lcds_decoder_props
bind lcds_decoder lcds_decoder_props i_lcds_decoder_props (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .ram_we_o(ram_we_o), .ram_col_o(ram_col_o),
	.ram_bank_o(ram_bank_o), .lcd_outputs_off_o(lcd_outputs_off_o),
	.bias_gen_en_o(bias_gen_en_o), .osc_en_o(osc_en_o), .charge_pump_en_o(charge_pump_en_o),
	.display_mode_o(display_mode_o), .row_map_sel_o(row_map_sel_o), .settings_o(settings_o));
`default_nettype wire

// ===== dv/lcds_host_model.sv
// host side model: drives the reset pad
// assumes the bench clock; pulses reset from power-up, then on request
`timescale 1ns/10ps
`default_nettype none
module lcds_host_model (
	input wire logic clk_i,
	input wire logic req_rst_i,
	output logic rst_o
);
	logic [3:0] cnt_reg = 4'h0;
	// count twelve cycles of power-up reset
	always_ff @(posedge clk_i) begin
		if (cnt_reg != 4'hc) begin
			cnt_reg <= cnt_reg + 4'h1;
		end
	end
	assign rst_o = (cnt_reg != 4'hc) || req_rst_i;
endmodule // lcds_host_model
`default_nettype wire

// ===== dv/lcds_decoder_tb.sv
// testbench of the lcd setting decoder, commands sent over wishbone
// assumes the design's 1-cycle ack and the host model's reset pulse
`timescale 1ns/10ps
`default_nettype none
module lcds_decoder_tb;
	import lcds_pkg::*;
	logic clk_i = 0, rst_i, cyc = 0, stb = 0, we = 0, req_rst = 0, ack;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0, rd, q;
	logic [1:0] mode;
	lcds_set_type set, e;
	logic pump;
	int errors = 0, n_checks = 0;
	lcds_host_model i_lcds_host_model (.clk_i(clk_i), .req_rst_i(req_rst), .rst_o(rst_i));
	lcds_decoder i_lcds_decoder (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(q),
		.wb_ack_o(ack), .ram_wdata_o(), .ram_we_o(), .ram_col_o(), .ram_bank_o(),
		.lcd_outputs_off_o(), .bias_gen_en_o(), .osc_en_o(), .charge_pump_en_o(pump),
		.display_mode_o(mode), .row_map_sel_o(), .settings_o(set));
	// 25 MHz clock
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	task wrap_up();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
			errors++;
		end
	endtask
	// one classic cycle: hold until ack, take data, release for one cycle
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			errors++;
			wrap_up();
		end
		rd = q;
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
	endtask
	task cmd(input logic [7:0] b);
		wb(1'b1, LCDS_ADR_BYTE, {24'h0, b});
	endtask
	task data(input logic [7:0] b);
		wb(1'b1, LCDS_ADR_BYTE, {23'h0, 1'b1, b});
	endtask
	task rdchk(input logic [3:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	// command sequence with expected settings kept in e
	initial begin
		repeat (14) @(posedge clk_i);
		e = LCDS_SET_RESET;
		rdchk(LCDS_ADR_STAT, 32'(e));
		rdchk(LCDS_ADR_PTR, 32'h0);
		rdchk(4'h2, 32'h0);
		data(8'ha5);
		rdchk(LCDS_ADR_PTR, 32'h1);
		cmd(8'h20);
		for (int i = 0; i < 4; i++) begin
			cmd(8'h08 | {5'h0, i[1], 1'b0, i[0]});
			chk(32'(mode), 32'(i));
			cmd(8'h10 | {6'h0, i[1:0]});
			chk(32'(set.multiplier_stage_sel), 32'(i));
		end
		cmd(8'h05);
		chk(32'(pump), 32'h1);
		cmd(8'h04);
		chk(32'(pump), 32'h0);
		cmd(8'h48);
		cmd(8'he5);
		cmd(8'he6);
		cmd(8'h49);
		rdchk(LCDS_ADR_PTR, 32'h465);
		cmd(8'h40);
		data(8'h3c);
		rdchk(LCDS_ADR_PTR, 32'h80);
		cmd(8'h22);
		cmd(8'h81);
		data(8'h11);
		data(8'h22);
		rdchk(LCDS_ADR_PTR, 32'h181);
		cmd(8'h29);
		cmd(8'h06);
		cmd(8'h15);
		cmd(8'h0b);
		cmd(8'hc0);
		cmd(8'h48);
		rdchk(LCDS_ADR_PTR, 32'h181);
		e = '{power_down_flag: 1'b0, extended_set_sel: 1'b1, row_flip: 1'b1, display_mode_hi: 1'b1,
			display_mode_lo: 1'b1, multiplier_stage_sel: 2'h3, temp_coeff_sel: 2'h2,
			bias_factor_sel: 3'h5, upper_row_block_flip: 1'b1, lower_row_block_flip: 1'b1,
			drive_level_code: 7'h40, default: 1'b0};
		rdchk(LCDS_ADR_STAT, 32'(e));
		chk(32'(pump), 32'h1);
		// mirrored write lands at the far column; host reads it back unmirrored after the change
		cmd(8'h38);
		cmd(8'h40);
		cmd(8'h80);
		data(8'h5a);
		cmd(8'h28);
		cmd(8'he5);
		rdchk(LCDS_ADR_RAM, 32'h5a);
		cmd(8'h80);
		rdchk(LCDS_ADR_RAM, 32'ha5);
		// bank 8 keeps only the top bit of a byte
		cmd(8'h48);
		data(8'hc3);
		cmd(8'h80);
		rdchk(LCDS_ADR_RAM, 32'h80);
		req_rst <= 1;
		repeat (3) @(posedge clk_i);
		req_rst <= 0;
		@(posedge clk_i);
		rdchk(LCDS_ADR_STAT, 32'(LCDS_SET_RESET));
		rdchk(LCDS_ADR_RAM, 32'ha5);
		wrap_up();
	end
endmodule // lcds_decoder_tb
`default_nettype wire
